/* File: hdl/mswd_pkg.sv */
package mswd_pkg;
  // Clock rate and time base
  localparam int CLK_HZ = 100_000_000;
  localparam int SECOND_S = 1;
  localparam int MINUTE_S = 60;
  localparam int SECOND_CYCLES = SECOND_S * CLK_HZ;
  localparam int MINUTE_SECONDS = MINUTE_S / SECOND_S;
  localparam int PRE_W = 27;
  localparam int MIN_W = 6;
  localparam int CNT_W = 8;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_NONE = 8'h00;
  localparam logic [7:0] IDX_PIN_SEL = 8'h2D;
  localparam logic [7:0] IDX_WDT_CTRL = 8'hF5;
  localparam logic [7:0] IDX_WDT_COUNT = 8'hF6;
  localparam logic [7:0] IDX_WDT_STATUS = 8'hF7;
  localparam logic [7:0] IDX_ALT_EN = 8'hF8;
  localparam logic [7:0] IDX_INT_STAT = 8'hF9;
  localparam logic [7:0] IDX_INT_MASK = 8'hFA;
  // Field positions
  localparam int PIN_SEL_BIT = 0;
  localparam int UNIT_BIT = 3;
  localparam int STATUS_BIT = 4;
  localparam int INT_EXPIRE_BIT = 0;
  localparam int INT_LOAD_BIT = 1;
  localparam int ALT_W = 4;
  localparam int INT_W = 2;
  // Reset values
  localparam logic RST_PIN_SEL = 1'h0;
  localparam logic RST_UNIT = 1'h0;
  localparam logic [CNT_W-1:0] RST_COUNT = 8'h00;
  localparam logic [ALT_W-1:0] RST_ALT_EN = 4'h0;
  localparam logic [INT_W-1:0] RST_INT_MASK = 2'h0;
  localparam logic SYNC_IDLE = 1'h1;
  // Counter constants and bus codes
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;
endpackage : mswd_pkg

/* File: hdl/mswd_tick_if.sv */
`timescale 1ns/1ps
// Control from the counter to the prescaler and the tick back
interface mswd_tick_if;
  logic clear;
  logic unit_min;
  logic tick;
  modport ctrl (output clear, output unit_min, input tick);
  modport pre (input clear, input unit_min, output tick);
endinterface : mswd_tick_if

/* File: hdl/mswd_prescaler.sv */
`timescale 1ns/1ps
module mswd_prescaler #(
  parameter int SECOND_CYCLES = mswd_pkg::SECOND_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  mswd_tick_if.pre tk
);
  typedef struct packed {
    logic [mswd_pkg::PRE_W-1:0] sub;
    logic [mswd_pkg::MIN_W-1:0] secs;
    logic tick;
  } mswd_pre_t;

  localparam logic [mswd_pkg::PRE_W-1:0] SUB_LAST = mswd_pkg::PRE_W'(SECOND_CYCLES - 1);
  localparam logic [mswd_pkg::MIN_W-1:0] SEC_LAST =
    mswd_pkg::MIN_W'(mswd_pkg::MINUTE_SECONDS - 1);

  mswd_pre_t s_reg;
  mswd_pre_t s_next;

  // Cycle divider, then seconds divider for the minute base
  always_comb
  begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (tk.clear)
    begin
      s_next.sub = '0;
      s_next.secs = '0;
    end
    else if (s_reg.sub == SUB_LAST)
    begin
      s_next.sub = '0;
      if (!tk.unit_min)
      begin
        s_next.tick = 1'b1;
      end
      else if (s_reg.secs >= SEC_LAST)
      begin
        s_next.secs = '0;
        s_next.tick = 1'b1;
      end
      else
      begin
        s_next.secs = s_reg.secs + 1'b1;
      end
    end
    else
    begin
      s_next.sub = s_reg.sub + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // A tick already out when a load lands would eat a step of the new count
  assign tk.tick = s_reg.tick && !tk.clear;

  presc_clear_a: assert property (@(posedge clk) disable iff (srst)
    tk.clear |=> !tk.tick && s_reg.sub == '0 && s_reg.secs == '0)
    else $error("prescaler not restarted by load");

  tick_unit_a: assert property (@(posedge clk) disable iff (srst)
    tk.tick |-> s_reg.sub == '0 && $past(s_reg.sub) == SUB_LAST
      && (!$past(tk.unit_min) || s_reg.secs == '0))
    else $error("tick not at end of selected unit");
endmodule : mswd_prescaler

/* File: hdl/mswd_top.sv */
`timescale 1ns/1ps
module mswd_top #(
  parameter int SECOND_CYCLES = mswd_pkg::SECOND_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic lpc_reset_n,
  input wire logic power_good_in,
  input wire logic gpio_p5b0_do,
  input wire logic gpio_p5b0_oe_n,
  output logic watchdog_expired_n,
  output logic shared_io_port5_bit0_o,
  output logic shared_io_port5_bit0_oe_n,
  output logic alt_expiry_pin_a_o,
  output logic alt_expiry_pin_a_oe_n,
  output logic alt_expiry_pin_b_o,
  output logic alt_expiry_pin_b_oe_n,
  output logic alt_expiry_pin_c_o,
  output logic alt_expiry_pin_c_oe_n,
  output logic alt_expiry_pin_d_o,
  output logic alt_expiry_pin_d_oe_n,
  output logic irq
);
  typedef struct packed {
    logic lrst_s1;
    logic lrst_s2;
    logic pgood_s1;
    logic pgood_s2;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic pin_sel;
    logic unit_min;
    logic [mswd_pkg::CNT_W-1:0] count;
    logic running;
    logic expired;
    logic [mswd_pkg::ALT_W-1:0] alt_en;
    logic [mswd_pkg::INT_W-1:0] int_stat;
    logic [mswd_pkg::INT_W-1:0] int_mask;
    logic presc_clr;
    logic [31:0] hrdata;
  } mswd_state_t;

  localparam mswd_state_t RST_STATE = '{
    lrst_s1: mswd_pkg::SYNC_IDLE,
    lrst_s2: mswd_pkg::SYNC_IDLE,
    pgood_s1: mswd_pkg::SYNC_IDLE,
    pgood_s2: mswd_pkg::SYNC_IDLE,
    pin_sel: mswd_pkg::RST_PIN_SEL,
    unit_min: mswd_pkg::RST_UNIT,
    count: mswd_pkg::RST_COUNT,
    alt_en: mswd_pkg::RST_ALT_EN,
    int_mask: mswd_pkg::RST_INT_MASK,
    default: '0
  };

  mswd_state_t s_reg;
  mswd_state_t s_next;
  logic addr_ok;
  logic [7:0] addr_idx;
  logic expire_ev;
  logic load_ev;
  logic hw_clear;

  mswd_tick_if tick_bus ();

  // Word index of a byte address; an address above the 1 KB window or not word aligned gives the null index
  function automatic logic [7:0] reg_index(input logic [31:0] addr);
    logic [7:0] idx;
    idx = mswd_pkg::IDX_NONE;
    if (addr[31:10] == '0 && addr[1:0] == 2'h0)
    begin
      idx = addr[9:2];
    end
    return idx;
  endfunction : reg_index

  // Read view of the register file; unmapped and reserved bits read zero
  function automatic logic [31:0] read_word(input logic [7:0] idx, input mswd_state_t st);
    logic [31:0] rd;
    rd = '0;
    if (idx == mswd_pkg::IDX_PIN_SEL)
    begin
      rd[mswd_pkg::PIN_SEL_BIT] = st.pin_sel;
    end
    else if (idx == mswd_pkg::IDX_WDT_CTRL)
    begin
      rd[mswd_pkg::UNIT_BIT] = st.unit_min;
    end
    else if (idx == mswd_pkg::IDX_WDT_COUNT)
    begin
      rd[mswd_pkg::CNT_W-1:0] = st.count;
    end
    else if (idx == mswd_pkg::IDX_WDT_STATUS)
    begin
      rd[mswd_pkg::STATUS_BIT] = st.expired;
    end
    else if (idx == mswd_pkg::IDX_ALT_EN)
    begin
      rd[mswd_pkg::ALT_W-1:0] = st.alt_en;
    end
    else if (idx == mswd_pkg::IDX_INT_STAT)
    begin
      rd[mswd_pkg::INT_W-1:0] = st.int_stat;
    end
    else if (idx == mswd_pkg::IDX_INT_MASK)
    begin
      rd[mswd_pkg::INT_W-1:0] = st.int_mask;
    end
    return rd;
  endfunction : read_word

  // Address phase decode; only whole-word transfers are taken
  assign addr_ok = hsel && hready && htrans[1] && hsize == mswd_pkg::SIZE_WORD;
  assign addr_idx = reg_index(haddr);
  // count runs out on this tick
  assign expire_ev = s_reg.running && tick_bus.tick && s_reg.count == mswd_pkg::CNT_ONE;
  assign load_ev = s_reg.wr_pend && s_reg.wr_idx == mswd_pkg::IDX_WDT_COUNT
    && hwdata[mswd_pkg::CNT_W-1:0] != mswd_pkg::CNT_ZERO;
  // synchronised bus reset or power loss
  assign hw_clear = !s_reg.lrst_s2 || !s_reg.pgood_s2;

  // Next state: sync, countdown, bus writes, hardware sets, read capture
  always_comb
  begin
    s_next = s_reg;
    s_next.presc_clr = 1'b0;
    s_next.hrdata = '0;
    s_next.lrst_s1 = lpc_reset_n;
    s_next.lrst_s2 = s_reg.lrst_s1;
    s_next.pgood_s1 = power_good_in;
    s_next.pgood_s2 = s_reg.pgood_s1;
    if (s_reg.running && tick_bus.tick)
    begin
      s_next.count = s_reg.count - mswd_pkg::CNT_ONE;
      if (expire_ev)
      begin
        s_next.running = 1'b0;
      end
    end
    // Data phase of a write; a load overrides a same-cycle step
    if (s_reg.wr_pend)
    begin
      if (s_reg.wr_idx == mswd_pkg::IDX_PIN_SEL)
      begin
        s_next.pin_sel = hwdata[mswd_pkg::PIN_SEL_BIT];
      end
      else if (s_reg.wr_idx == mswd_pkg::IDX_WDT_CTRL)
      begin
        s_next.unit_min = hwdata[mswd_pkg::UNIT_BIT];
      end
      else if (s_reg.wr_idx == mswd_pkg::IDX_WDT_COUNT)
      begin
        s_next.count = hwdata[mswd_pkg::CNT_W-1:0];
        s_next.running = 1'b0;
        if (load_ev)
        begin
          s_next.running = 1'b1;
          s_next.presc_clr = 1'b1;
        end
      end
      else if (s_reg.wr_idx == mswd_pkg::IDX_WDT_STATUS)
      begin
        if (!hwdata[mswd_pkg::STATUS_BIT])
        begin
          s_next.expired = 1'b0;
        end
      end
      else if (s_reg.wr_idx == mswd_pkg::IDX_ALT_EN)
      begin
        s_next.alt_en = hwdata[mswd_pkg::ALT_W-1:0];
      end
      else if (s_reg.wr_idx == mswd_pkg::IDX_INT_STAT)
      begin
        s_next.int_stat = s_reg.int_stat & ~hwdata[mswd_pkg::INT_W-1:0];
      end
      else if (s_reg.wr_idx == mswd_pkg::IDX_INT_MASK)
      begin
        s_next.int_mask = hwdata[mswd_pkg::INT_W-1:0];
      end
    end
    // set status; applied after writes so a set beats a clear
    if (expire_ev)
    begin
      s_next.expired = 1'b1;
      s_next.int_stat[mswd_pkg::INT_EXPIRE_BIT] = 1'b1;
    end
    if (load_ev)
    begin
      s_next.int_stat[mswd_pkg::INT_LOAD_BIT] = 1'b1;
    end
    // reset clear has the last word, it is a reset
    if (hw_clear)
    begin
      s_next.expired = 1'b0;
    end
    // Capture address phase of the next transfer
    s_next.wr_pend = addr_ok && hwrite;
    s_next.wr_idx = addr_idx;
    // Reads see this cycle's writes, so write-then-read needs no wait
    if (addr_ok && !hwrite)
    begin
      s_next.hrdata = read_word(addr_idx, s_next);
    end
  end

  // Single state register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_reg <= RST_STATE;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Time base
  assign tick_bus.clear = s_reg.presc_clr;
  assign tick_bus.unit_min = s_reg.unit_min;

  mswd_prescaler #(
    .SECOND_CYCLES(SECOND_CYCLES)
  ) u_prescaler (
    .clk(clk),
    .srst(srst),
    .tk(tick_bus)
  );

  // Bus answers at once and always OKAY
  assign hrdata = s_reg.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = mswd_pkg::HRESP_OKAY;
  assign irq = |(s_reg.int_stat & s_reg.int_mask);

  // expiry output, low while status set
  assign watchdog_expired_n = !s_reg.expired;

  // shared pin; otherwise the port-5 GPIO drives it
  assign shared_io_port5_bit0_o = s_reg.pin_sel ? gpio_p5b0_do : !s_reg.expired;
  assign shared_io_port5_bit0_oe_n = s_reg.pin_sel ? gpio_p5b0_oe_n : 1'b0;

  // alternates: a, c, d open-drain, b push-pull
  assign alt_expiry_pin_a_o = 1'b0;
  assign alt_expiry_pin_a_oe_n = !(s_reg.alt_en[0] && s_reg.expired);
  assign alt_expiry_pin_b_o = !s_reg.expired;
  assign alt_expiry_pin_b_oe_n = !s_reg.alt_en[1];
  assign alt_expiry_pin_c_o = 1'b0;
  assign alt_expiry_pin_c_oe_n = !(s_reg.alt_en[2] && s_reg.expired);
  assign alt_expiry_pin_d_o = 1'b0;
  assign alt_expiry_pin_d_oe_n = !(s_reg.alt_en[3] && s_reg.expired);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Steps of a load, of an expiry and of a status clear
  sequence load_req_s;
    load_ev;
  endsequence

  sequence expire_s;
    expire_ev && !s_reg.wr_pend && !hw_clear;
  endsequence

  sequence status_clr_s;
    s_reg.wr_pend && s_reg.wr_idx == mswd_pkg::IDX_WDT_STATUS
      && !hwdata[mswd_pkg::STATUS_BIT] && !expire_ev;
  endsequence

  pin_mux_a: assert property (
    !s_reg.pin_sel |-> !shared_io_port5_bit0_oe_n
      && shared_io_port5_bit0_o == watchdog_expired_n)
    else $error("shared pin not carrying expiry");

  count_step_a: assert property (
    s_reg.running && tick_bus.tick && !s_reg.wr_pend
      |=> s_reg.count == mswd_pkg::CNT_W'($past(s_reg.count) - mswd_pkg::CNT_ONE))
    else $error("counter did not step down by one");

  unit_sel_a: assert property (
    s_reg.wr_pend && s_reg.wr_idx == mswd_pkg::IDX_WDT_CTRL
      |=> tick_bus.unit_min == $past(hwdata[mswd_pkg::UNIT_BIT]))
    else $error("unit select not applied");

  zero_off_a: assert property (
    s_reg.wr_pend && s_reg.wr_idx == mswd_pkg::IDX_WDT_COUNT
      && hwdata[mswd_pkg::CNT_W-1:0] == mswd_pkg::CNT_ZERO
      |=> !s_reg.running ##1 (!s_reg.running || $past(load_ev)))
    else $error("zero write did not disable");

  // expiry only from a running count
  no_idle_exp_a: assert property (
    $rose(s_reg.expired) |-> $past(s_reg.running))
    else $error("expiry without countdown");

  load_start_a: assert property (
    load_req_s |=> s_reg.running && tick_bus.clear
      && s_reg.count == $past(hwdata[mswd_pkg::CNT_W-1:0]))
    else $error("non-zero write did not start");

  expire_a: assert property (
    expire_s |=> !s_reg.running && !watchdog_expired_n
      && s_reg.int_stat[mswd_pkg::INT_EXPIRE_BIT])
    else $error("expiry not signalled");

  status_clr_a: assert property (
    status_clr_s |=> watchdog_expired_n && !s_reg.expired)
    else $error("status clear did not release pin");

  rst_clr_a: assert property (
    hw_clear |=> !s_reg.expired ##0 watchdog_expired_n)
    else $error("bus reset did not clear status");

  alt_pins_a: assert property (
    s_reg.expired && s_reg.alt_en[0] && s_reg.alt_en[1]
      |-> !alt_expiry_pin_a_oe_n && !alt_expiry_pin_b_oe_n && !alt_expiry_pin_b_o)
    else $error("alternate pin not driven");

  presc_load_a: assert property (
    tick_bus.clear |-> $past(load_ev))
    else $error("prescaler clear without load");
endmodule : mswd_top

/* File: tb/mswd_board.sv */
`timescale 1ns/1ps
// Board side of the expiry nets: pull-ups, and a counter of alarms seen
module mswd_board (
  input wire logic clk,
  input wire logic [4:0] pin_o,
  input wire logic [4:0] pin_oe_n,
  output logic [4:0] level,
  output logic [7:0] n_alarm
);
  logic last_b = 1'b0;
  logic prev_alarm = 1'b1;
  logic [7:0] alarm_cnt = 8'h00;
  assign n_alarm = alarm_cnt;
  // Open-drain nets float high; the released push-pull net shows a stale inverse
  always_comb
  begin
    level = 5'h1F;
    for (int i = 0; i < 5; i++)
    begin
      if (pin_oe_n[i] == 1'b0)
      begin
        level[i] = pin_o[i];
      end
    end
    if (pin_oe_n[2] != 1'b0)
    begin
      level[2] = ~last_b;
    end
  end
  always @(posedge clk)
  begin
    if (pin_oe_n[2] == 1'b0)
    begin
      last_b <= pin_o[2];
    end
    prev_alarm <= level[0];
    if (prev_alarm == 1'b1 && level[0] == 1'b0)
    begin
      alarm_cnt <= alarm_cnt + 8'h01;
    end
  end
endmodule : mswd_board

/* File: tb/test_minute_second_watchdog.sv */
`timescale 1ns/1ps
module test_minute_second_watchdog;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic lpc_reset_n = 1'b1;
  logic power_good_in = 1'b1;
  logic gpio_do = 1'b0;
  logic gpio_oe_n = 1'b1;
  logic expired_n;
  logic irq;
  logic [4:0] pin_o;
  logic [4:0] pin_oe_n;
  logic [4:0] level;
  logic [7:0] n_alarm;
  logic [31:0] rd_neg = 32'h00000000;
  logic rdy_neg = 1'b0;
  logic [31:0] q;
  logic [7:0] idx_l [8] = '{mswd_pkg::IDX_PIN_SEL, mswd_pkg::IDX_WDT_CTRL,
    mswd_pkg::IDX_WDT_COUNT, mswd_pkg::IDX_WDT_STATUS, mswd_pkg::IDX_ALT_EN,
    mswd_pkg::IDX_INT_STAT, mswd_pkg::IDX_INT_MASK, 8'h10};
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  int n;

  mswd_top #(.SECOND_CYCLES(10)) u_mswd_top (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(mswd_pkg::SIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .lpc_reset_n(lpc_reset_n), .power_good_in(power_good_in),
    .gpio_p5b0_do(gpio_do), .gpio_p5b0_oe_n(gpio_oe_n), .watchdog_expired_n(expired_n),
    .shared_io_port5_bit0_o(pin_o[0]), .shared_io_port5_bit0_oe_n(pin_oe_n[0]),
    .alt_expiry_pin_a_o(pin_o[1]), .alt_expiry_pin_a_oe_n(pin_oe_n[1]),
    .alt_expiry_pin_b_o(pin_o[2]), .alt_expiry_pin_b_oe_n(pin_oe_n[2]),
    .alt_expiry_pin_c_o(pin_o[3]), .alt_expiry_pin_c_oe_n(pin_oe_n[3]),
    .alt_expiry_pin_d_o(pin_o[4]), .alt_expiry_pin_d_oe_n(pin_oe_n[4]),
    .irq(irq)
  );

  mswd_board u_mswd_board (
    .clk(clk), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .level(level), .n_alarm(n_alarm)
  );

  // Clock of 100 MHz
  initial forever #5 clk = ~clk;

  // Bus answers copied mid-cycle, so the edge sample never races the registers
  always @(negedge clk)
  begin
    rd_neg <= hrdata;
    rdy_neg <= hreadyout;
  end

  // Hang guard, well above the longest expected run
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({31'h00000000, got}, {31'h00000000, exp});
  endtask : chk1

  // Address phase held until ready, then data phase held until ready
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h000000, idx, 2'h0};
    do @(posedge clk); while (rdy_neg !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (rdy_neg !== 1'b1);
    q = rd_neg;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h00000000);
    chk(q, exp);
  endtask : rdchk

  // Counts cycles, sampled mid-cycle, until expiry shows or the limit runs out
  task automatic wait_exp(input int limit);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (expired_n !== 1'b0 && n < limit);
  endtask : wait_exp

  // Pulse one of the clearing inputs low for a few cycles
  task automatic pulse_clear(input logic is_pg);
    @(posedge clk);
    if (is_pg)
      power_good_in <= 1'b0;
    else
      lpc_reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk1(expired_n, 1'b1);
    @(posedge clk);
    power_good_in <= 1'b1;
    lpc_reset_n <= 1'b1;
    rdchk(mswd_pkg::IDX_WDT_STATUS, 32'h00000000);
  endtask : pulse_clear

  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      rdchk(idx_l[i], 32'h00000000);
    end
    @(negedge clk);
    chk1(expired_n, 1'b1);
    chk1(level[0], 1'b1);
    chk1(irq, 1'b0);
    chk1(hresp, 1'b0);
    $display("test done: reset");
    // full width count, then zero disables
    wr(mswd_pkg::IDX_WDT_COUNT, 32'h000000FF);
    rdchk(mswd_pkg::IDX_WDT_COUNT, 32'h000000FF);
    wr(mswd_pkg::IDX_WDT_COUNT, 32'h00000001);
    wr(mswd_pkg::IDX_WDT_COUNT, 32'h00000000);
    rdchk(mswd_pkg::IDX_WDT_COUNT, 32'h00000000);
    wait_exp(60);
    chk1(expired_n, 1'b1);
    $display("test done: disable");
    // reload restarts the time base, seconds expiry follows
    wr(mswd_pkg::IDX_INT_MASK, 32'h00000001);
    wr(mswd_pkg::IDX_WDT_COUNT, 32'h00000002);
    repeat (5) @(posedge clk);
    wr(mswd_pkg::IDX_WDT_COUNT, 32'h00000002);
    wait_exp(60);
    chk(32'(n >= 20 && n <= 26), 32'h00000001);
    chk1(level[0], 1'b0);
    chk1(irq, 1'b1);
    rdchk(mswd_pkg::IDX_WDT_STATUS, 32'h00000010);
    chk({24'h000000, n_alarm}, 32'h00000001);
    repeat (30) @(posedge clk);
    rdchk(mswd_pkg::IDX_WDT_COUNT, 32'h00000000);
    $display("test done: seconds expiry");
    // only a zero clears the status
    wr(mswd_pkg::IDX_WDT_STATUS, 32'h00000010);
    rdchk(mswd_pkg::IDX_WDT_STATUS, 32'h00000010);
    wr(mswd_pkg::IDX_WDT_STATUS, 32'h00000000);
    rdchk(mswd_pkg::IDX_WDT_STATUS, 32'h00000000);
    @(negedge clk);
    chk1(expired_n, 1'b1);
    chk1(level[0], 1'b1);
    rdchk(mswd_pkg::IDX_INT_STAT, 32'h00000003);
    wr(mswd_pkg::IDX_INT_MASK, 32'h00000000);
    @(negedge clk);
    chk1(irq, 1'b0);
    wr(mswd_pkg::IDX_INT_STAT, 32'h00000003);
    rdchk(mswd_pkg::IDX_INT_STAT, 32'h00000000);
    $display("test done: clear and interrupt");
    wr(mswd_pkg::IDX_WDT_CTRL, 32'h00000008);
    rdchk(mswd_pkg::IDX_WDT_CTRL, 32'h00000008);
    wr(mswd_pkg::IDX_WDT_COUNT, 32'h00000001);
    wait_exp(700);
    chk(32'(n >= 600 && n <= 670), 32'h00000001);
    wr(mswd_pkg::IDX_WDT_CTRL, 32'h00000000);
    $display("test done: minutes");
    // alternative pins, shared pin handed to the port
    wr(mswd_pkg::IDX_ALT_EN, 32'h0000000F);
    @(negedge clk);
    chk({27'h0000000, level}, 32'h00000000);
    wr(mswd_pkg::IDX_ALT_EN, 32'h00000000);
    @(negedge clk);
    chk1(level[1], 1'b1);
    chk1(level[3], 1'b1);
    chk1(level[4], 1'b1);
    @(posedge clk);
    gpio_do <= 1'b1;
    gpio_oe_n <= 1'b0;
    wr(mswd_pkg::IDX_PIN_SEL, 32'h00000001);
    @(negedge clk);
    chk1(level[0], 1'b1);
    wr(mswd_pkg::IDX_PIN_SEL, 32'h00000000);
    @(negedge clk);
    chk1(level[0], 1'b0);
    $display("test done: pins");
    // power loss and bus reset both clear the status
    pulse_clear(1'b1);
    wr(mswd_pkg::IDX_WDT_COUNT, 32'h00000001);
    wait_exp(40);
    chk1(expired_n, 1'b0);
    pulse_clear(1'b0);
    $display("test done: external clears");
    wrap_up();
  end
endmodule : test_minute_second_watchdog
